// *** shared/ddos_pkg.sv ***
// Shared constants and types for the dual DAC output sequencer
package ddos_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int SPI_BPS_DEF = 50000;
    localparam int SPI_BPS_MAX = 1_000_000;
    localparam int HALF_DEF = CLK_HZ / (2 * SPI_BPS_DEF);
    localparam int HALF_MIN = (CLK_HZ + 2 * SPI_BPS_MAX - 1) / (2 * SPI_BPS_MAX);
    localparam int CS_HOLD_NS = 1000;
    localparam int CS_HOLD_CYC = (CS_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int REF_SETTLE_US = 10;
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int GAP_CYC = CS_HOLD_CYC;
    localparam logic [7:0] CMD_REF = 8'h38;
    localparam logic [7:0] REF_HI = 8'h00;
    localparam logic [7:0] REF_LO = 8'h01;
    localparam logic [7:0] CMD_BOTH = 8'h17;
    localparam logic [7:0] CMD_CHA = 8'h00;
    localparam logic [7:0] CMD_CHB = 8'h01;
    localparam logic [15:0] CODE_MID = 16'h7FFF;
    localparam logic [7:0] JMP_CHAN_DRIVE = 8'hAA;
    localparam logic [7:0] JMP_MODE_DRIVE = 8'h02;
    localparam int SEL_PH1_BIT = 2;
    localparam int SEL_PH2_BIT = 4;
    localparam int SEL_PH3_BIT = 6;
    localparam int MODE0_BIT = 0;
    localparam int MODE1_BIT = 2;
    localparam logic MODE0_RST = 1'b0;
    localparam logic MODE1_RST = 1'b1;
    localparam int CUR_STEP = 1000;
    localparam int VOLT_STEP = 250;
    localparam logic [12:0][15:0] CUR_TAB = {16'hF7FF, 16'hEDFF, 16'hE3FF, 16'hD9FF,
        16'hCFFF, 16'hC5FF, 16'hBBFF, 16'hB1FF, 16'hA7FF, 16'h9DFF, 16'h93FF,
        16'h89FF, 16'h7FFF};
    localparam logic [13:0][15:0] VOLT_TAB = {16'hF4FF, 16'hEBFF, 16'hE2FF, 16'hD9FF,
        16'hD0FF, 16'hC7FF, 16'hBEFF, 16'hB5FF, 16'hACFF, 16'hA3FF, 16'h9AFF,
        16'h91FF, 16'h88FF, 16'h7FFF};

    typedef struct packed {
        logic [15:0] cur;
        logic [15:0] volt;
    } ddos_rms_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_CS = 6'b00_0010,
        ST_LOAD = 6'b00_0100,
        ST_SHIFT = 6'b00_1000,
        ST_HOLD = 6'b01_0000,
        ST_GAP = 6'b10_0000
    } ddos_state_t;
endpackage : ddos_pkg

// *** rtl/ddos_spi_shifter.sv ***
// Byte shifter: clock idles high, capture on first edge, MSB first
`timescale 1ns/1ns
module ddos_spi_shifter
    import ddos_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [DIV_W-1:0] half_div,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic miso,
    output logic sclk_q,
    output logic mosi_q,
    output logic busy_q,
    output logic done_q,
    output logic [7:0] rx_q
);
    logic [DIV_W-1:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sclk_q <= 1'b1;
            mosi_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rx_q <= 8'h00;
            cnt_q <= '0;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (!busy_q) begin
                sclk_q <= 1'b1;
                if (start) begin
                    busy_q <= 1'b1;
                    sh_q <= tx_byte;
                    mosi_q <= tx_byte[7];
                    cnt_q <= half_div;
                    bit_q <= 3'h7;
                end
            end else if (cnt_q > 1) begin
                cnt_q <= cnt_q - 1'b1;
            end else begin
                cnt_q <= half_div;
                if (sclk_q) begin
                    sclk_q <= 1'b0;
                    rx_q <= {rx_q[6:0], miso};
                end else begin
                    sclk_q <= 1'b1;
                    if (bit_q == 3'h0) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        bit_q <= bit_q - 1'b1;
                        sh_q <= {sh_q[6:0], 1'b0};
                        mosi_q <= sh_q[6];
                    end
                end
            end
        end
    end
endmodule : ddos_spi_shifter

// *** rtl/ddos_interp.sv ***
// Table lookup with linear interpolation between entries
`timescale 1ns/1ns
module ddos_interp
    import ddos_pkg::*;
#(
    parameter int N = 13,
    parameter int STEP = 1000,
    parameter logic [N-1:0][15:0] TAB = '0
) (
    input wire logic [15:0] x,
    output logic [15:0] code
);
    always_comb begin
        int i;
        int r;
        int a;
        int b;
        i = int'(x) / STEP;
        r = int'(x) - i * STEP;
        if (i > N - 2) begin
            i = N - 2;
            r = STEP;
        end
        a = int'(TAB[i]);
        b = int'(TAB[i + 1]);
        code = 16'(a + ((b - a) * r) / STEP);
    end
endmodule : ddos_interp

// *** rtl/ddos_dac_seq.sv ***
// Dual DAC output sequencer: SPI framing, jumper sensing, mode, relay and LED pins
// Summary of operation
// - Bytes shift MSB first, input sampled first edge, output changed next.
// - Serial clock stays high whenever no transfer runs.
// - Three wires only; chip select comes from a separate output.
// - Programmable divider; default 50000 bps, up to about 1 Mbps.
// - Chip select low before a command, raised after a short tail delay.
// - A byte is loaded only while the shifter is idle.
// - Init sends 0x38 0x00 0x01 then waits for reference settling.
// - Frame is command, code high byte, code low byte; 0x17/0x00/0x01.
// - After init both channels get mid-scale code 0x7FFF.
// - Alternate channel jumper lines and mode jumper line 1 driven high; fitted jumper reads one.
// - Jumpers are resampled on every update routine run.
// - Bits 2,4,6 pick phase 1,2,3; none selected gives mid-scale.
// - Mode jumper bit 0 drives channel 0 mode output directly.
// - Mode jumper bit 2 drives channel 1 mode output directly.
// - Reset leaves channel 0 mode low and channel 1 mode high.
// - Update runs each second; DAC codes refresh every other second.
// - Codes come from current and voltage tables with interpolation.
// - Relay outputs active high, all off after reset.
// - LED lit while its fault flag reads low; both off at reset.
// - Init clears receive flag, then enables receive-complete interrupt.
`timescale 1ns/1ns
module ddos_dac_seq
    import ddos_pkg::*;
#(
    parameter int PHASES = 3,
    parameter int RELAYS = 6
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic metro_strobe,
    input wire ddos_rms_t [PHASES-1:0] rms_in,
    input wire logic [15:0] rate_div,
    input wire logic [RELAYS-1:0] relay_req,
    input wire logic rx_flag_clr,
    input wire logic serial_data_in,
    input wire logic driver_fault_flag_1,
    input wire logic driver_fault_flag_2,
    input wire logic [7:0] channel_jumper_inputs,
    input wire logic [7:0] mode_jumper_inputs,
    output logic sclk,
    output logic serial_data_out,
    output logic dac_chip_select_n,
    output logic [7:0] channel_jumper_out,
    output logic [7:0] channel_jumper_oe,
    output logic [7:0] mode_jumper_out,
    output logic [7:0] mode_jumper_oe,
    output logic [1:0] driver_mode_outputs,
    output logic [RELAYS-1:0] relay_out,
    output logic [1:0] led_out,
    output logic spi_rx_irq,
    output logic [7:0] spi_rx_byte,
    output logic init_done,
    output logic frame_busy
);
    ddos_state_t state_q;
    logic [7:0] chan_s1_q, chan_s2_q, mode_s1_q, mode_s2_q;
    logic [1:0] flt_s1_q, flt_s2_q;
    logic miso_s1_q, miso_s2_q;
    logic [15:0] half_q;
    logic [15:0] cnt_q;
    logic [2:0][7:0] frame_q;
    logic [1:0] idx_q;
    logic spi_start, spi_busy, spi_done;
    logic [7:0] tx_byte;
    logic ref_done_q, mid_done_q, settle_q;
    logic upd_pend_q, pend_b_q, sec_q;
    ddos_rms_t [PHASES-1:0] rms_q;
    ddos_rms_t sel_rms;
    logic sel_any;
    logic [15:0] code_cur, code_volt, code_b_q;
    logic rx_flag_q, rx_ie_q;
    logic [1:0] mode_q;

    function automatic logic [1:0] pick_phase(input logic [7:0] j);
        if (j[SEL_PH1_BIT]) begin
            pick_phase = 2'd0;
        end else if (j[SEL_PH2_BIT]) begin
            pick_phase = 2'd1;
        end else begin
            pick_phase = 2'd2;
        end
    endfunction : pick_phase

    // Two-stage synchronisers for every pin input
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            chan_s1_q <= 8'h00;
            chan_s2_q <= 8'h00;
            mode_s1_q <= 8'h00;
            mode_s2_q <= 8'h00;
            flt_s1_q <= 2'b11;
            flt_s2_q <= 2'b11;
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            chan_s1_q <= channel_jumper_inputs;
            chan_s2_q <= chan_s1_q;
            mode_s1_q <= mode_jumper_inputs;
            mode_s2_q <= mode_s1_q;
            flt_s1_q <= {driver_fault_flag_2, driver_fault_flag_1};
            flt_s2_q <= flt_s1_q;
            miso_s1_q <= serial_data_in;
            miso_s2_q <= miso_s1_q;
        end
    end

    // Rate divider, clamped to the fastest allowed rate
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            half_q <= 16'(HALF_DEF);
        end else if (rate_div == 16'h0000) begin
            half_q <= 16'(HALF_DEF);
        end else if (rate_div < 16'(HALF_MIN)) begin
            half_q <= 16'(HALF_MIN);
        end else begin
            half_q <= rate_div;
        end
    end

    // Shifter has no select of its own
    ddos_spi_shifter #(.DIV_W(16)) u_shift (
        .core_clk(core_clk),
        .resetn(resetn),
        .half_div(half_q),
        .start(spi_start),
        .tx_byte(tx_byte),
        .miso(miso_s2_q),
        .sclk_q(sclk),
        .mosi_q(serial_data_out),
        .busy_q(spi_busy),
        .done_q(spi_done),
        .rx_q(spi_rx_byte)
    );

    assign tx_byte = frame_q[idx_q];
    assign spi_start = (state_q == ST_LOAD) && !spi_busy;

    // Phase selection, lowest fitted jumper first
    assign sel_any = chan_s2_q[SEL_PH1_BIT] | chan_s2_q[SEL_PH2_BIT] | chan_s2_q[SEL_PH3_BIT];
    assign sel_rms = rms_q[pick_phase(chan_s2_q)];

    ddos_interp #(.N(13), .STEP(CUR_STEP), .TAB(CUR_TAB)) u_cur (
        .x(sel_rms.cur),
        .code(code_cur)
    );

    ddos_interp #(.N(14), .STEP(VOLT_STEP), .TAB(VOLT_TAB)) u_volt (
        .x(sel_rms.volt),
        .code(code_volt)
    );

    // Metrology strobe is held until the running frame ends
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            upd_pend_q <= 1'b0;
            rms_q <= '0;
        end else begin
            if (metro_strobe) begin
                upd_pend_q <= 1'b1;
                rms_q <= rms_in;
            end else if (state_q == ST_IDLE && mid_done_q && !pend_b_q) begin
                upd_pend_q <= 1'b0;
            end
        end
    end

    // Frame sequencer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            frame_q <= '0;
            idx_q <= 2'd0;
            ref_done_q <= 1'b0;
            mid_done_q <= 1'b0;
            settle_q <= 1'b0;
            pend_b_q <= 1'b0;
            sec_q <= 1'b0;
            mode_q <= {MODE1_RST, MODE0_RST};
            code_b_q <= CODE_MID;
            dac_chip_select_n <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    idx_q <= 2'd0;
                    if (!ref_done_q) begin
                        frame_q <= {REF_LO, REF_HI, CMD_REF};
                        settle_q <= 1'b1;
                        state_q <= ST_CS;
                    end else if (!mid_done_q) begin
                        frame_q <= {CODE_MID[7:0], CODE_MID[15:8], CMD_BOTH};
                        mid_done_q <= 1'b1;
                        state_q <= ST_CS;
                    end else if (pend_b_q) begin
                        frame_q <= {code_b_q[7:0], code_b_q[15:8], CMD_CHB};
                        pend_b_q <= 1'b0;
                        state_q <= ST_CS;
                    end else if (upd_pend_q) begin
                        mode_q <= {mode_s2_q[MODE1_BIT], mode_s2_q[MODE0_BIT]};
                        sec_q <= !sec_q;
                        if (!sec_q) begin
                            if (sel_any) begin
                                frame_q <= {code_cur[7:0], code_cur[15:8], CMD_CHA};
                                code_b_q <= code_volt;
                                pend_b_q <= 1'b1;
                            end else begin
                                frame_q <= {CODE_MID[7:0], CODE_MID[15:8], CMD_BOTH};
                            end
                            state_q <= ST_CS;
                        end
                    end
                end
                ST_CS: begin
                    dac_chip_select_n <= 1'b0;
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (!spi_busy) begin
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (spi_done) begin
                        if (idx_q == 2'd2) begin
                            cnt_q <= 16'(CS_HOLD_CYC);
                            state_q <= ST_HOLD;
                        end else begin
                            idx_q <= idx_q + 2'd1;
                            state_q <= ST_LOAD;
                        end
                    end
                end
                ST_HOLD: begin
                    if (cnt_q > 16'h0001) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else begin
                        dac_chip_select_n <= 1'b1;
                        cnt_q <= settle_q ? 16'(REF_SETTLE_CYC) : 16'(GAP_CYC);
                        state_q <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (cnt_q > 16'h0001) begin
                        cnt_q <= cnt_q - 16'h0001;
                    end else begin
                        if (settle_q) begin
                            ref_done_q <= 1'b1;
                            settle_q <= 1'b0;
                        end
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Jumper drive, mode and status outputs
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            channel_jumper_out <= 8'h00;
            channel_jumper_oe <= 8'h00;
            mode_jumper_out <= 8'h00;
            mode_jumper_oe <= 8'h00;
            driver_mode_outputs <= {MODE1_RST, MODE0_RST};
            init_done <= 1'b0;
            frame_busy <= 1'b0;
        end else begin
            channel_jumper_out <= JMP_CHAN_DRIVE;
            channel_jumper_oe <= JMP_CHAN_DRIVE;
            mode_jumper_out <= JMP_MODE_DRIVE;
            mode_jumper_oe <= JMP_MODE_DRIVE;
            driver_mode_outputs <= mode_q;
            init_done <= mid_done_q && state_q == ST_IDLE;
            frame_busy <= state_q != ST_IDLE;
        end
    end

    // Relays and fault LEDs
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            relay_out <= '0;
            led_out <= 2'b00;
        end else begin
            relay_out <= relay_req;
            led_out <= ~flt_s2_q;
        end
    end

    // Receive flag, cleared and enabled during init; set beats clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rx_flag_q <= 1'b0;
            rx_ie_q <= 1'b0;
            spi_rx_irq <= 1'b0;
        end else begin
            if (spi_done && ref_done_q) begin
                rx_flag_q <= 1'b1;
            end else if (!ref_done_q || rx_flag_clr) begin
                rx_flag_q <= 1'b0;
            end
            rx_ie_q <= ref_done_q;
            spi_rx_irq <= rx_flag_q && rx_ie_q;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence seq_frame_end;
        (state_q == ST_HOLD) ##1 (state_q == ST_GAP);
    endsequence

    AST_MSB_FIRST: assert property (spi_start |=> serial_data_out == $past(tx_byte[7]))
        else $error("first bit not msb");
    AST_CLK_IDLE: assert property (!spi_busy && !$past(spi_busy) |-> sclk)
        else $error("clock low while idle");
    AST_RATE: assert property (half_q >= 16'(HALF_MIN))
        else $error("rate above limit");
    AST_CS_SPAN: assert property (state_q inside {ST_LOAD, ST_SHIFT} |-> !dac_chip_select_n)
        else $error("select high inside frame");
    AST_CS_TAIL: assert property ($rose(dac_chip_select_n) |-> $past(state_q, 2) == ST_HOLD)
        else $error("select released early");
    AST_LOAD_IDLE: assert property (spi_start |-> !spi_busy ##1 spi_busy)
        else $error("load while busy");
    AST_REF_CMD: assert property (spi_start && !ref_done_q |-> tx_byte ==
        ((idx_q == 2'd0) ? CMD_REF : ((idx_q == 2'd1) ? REF_HI : REF_LO)))
        else $error("bad reference command");
    AST_MODE_FOLLOW: assert property ((state_q == ST_IDLE) && upd_pend_q && mid_done_q
        && !pend_b_q && !metro_strobe |=> ##1 driver_mode_outputs
        == {$past(mode_s2_q[MODE1_BIT], 2), $past(mode_s2_q[MODE0_BIT], 2)})
        else $error("mode output not from jumper");
    AST_LED: assert property (##2 (led_out == ~$past(flt_s2_q)))
        else $error("led does not follow fault");
    AST_RELAY: assert property (##2 (relay_out == $past(relay_req)))
        else $error("relay does not follow request");
    AST_FRAME_END: assert property (seq_frame_end |-> dac_chip_select_n)
        else $error("select still low after frame");
endmodule : ddos_dac_seq

// *** verification/ddos_dac_model.sv ***
// Behavioural model of the dual-channel SPI DAC on the far side of the link
`timescale 1ns/1ns
module ddos_dac_model #(
    parameter logic [7:0] REPLY = 8'hA5
) (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso,
    output logic [23:0] frame,
    output int nframes,
    output logic bad
);
    logic [23:0] sh;
    int nb;
    bit open;
    initial begin
        miso = 1'b0;
        frame = '0;
        nframes = 0;
        bad = 1'b0;
        sh = '0;
        nb = 0;
        open = 1'b0;
    end
    // Readback bit 7 is presented as soon as the frame opens
    always @(negedge cs_n) begin
        open = 1'b1;
        nb = 0;
        miso = REPLY[7];
    end
    // Command and code bits captured on the falling edge, MSB first
    always @(negedge sclk) if (!cs_n) begin
        sh = {sh[22:0], mosi};
        nb = nb + 1;
    end
    always @(posedge sclk) if (!cs_n) begin
        miso = REPLY[7 - (nb % 8)];
    end
    // Frame closes on chip select; a short or long frame is flagged
    always @(posedge cs_n) if (open) begin
        if (nb != 24) begin
            bad = 1'b1;
        end
        frame = sh;
        nframes = nframes + 1;
        miso = ~miso;
        open = 1'b0;
    end
endmodule : ddos_dac_model

// *** verification/ddos_dac_seq_tb.sv ***
// Self-checking testbench for the dual DAC output sequencer
`timescale 1ns/1ns
module ddos_dac_seq_tb;
    import ddos_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic metro_strobe = 1'b0;
    ddos_rms_t [2:0] rms_in = '0;
    logic [15:0] rate_div = 16'h0019;
    logic [5:0] relay_req = '0;
    logic rx_flag_clr = 1'b0;
    logic flt1 = 1'b1;
    logic flt2 = 1'b1;
    logic [7:0] chan_fit = '0;
    logic [7:0] mode_fit = '0;
    logic miso, sclk, mosi, cs_n, irq, init_done, frame_busy, bad;
    logic [7:0] chan_in, chan_out, chan_oe, mode_in, mode_out, mode_oe, rx_byte;
    logic [1:0] modes, leds;
    logic [5:0] relay_out;
    logic [23:0] frame;
    int nframes;
    int num_errors = 0;
    int compares = 0;
    always #10 core_clk = ~core_clk;
    // Pin level: own drive, else the fitted jumper's source line, else pull-down
    function automatic logic [7:0] pinlvl(input logic [7:0] o, oe, fit, input bit md);
        for (int i = 0; i < 8; i++) begin
            pinlvl[i] = oe[i] ? o[i] : (fit[i] & o[md ? 1 : (i | 1)]);
        end
    endfunction : pinlvl
    assign chan_in = pinlvl(chan_out, chan_oe, chan_fit, 1'b0);
    assign mode_in = pinlvl(mode_out, mode_oe, mode_fit, 1'b1);
    ddos_dac_seq dut_u (.core_clk(core_clk), .resetn(resetn), .metro_strobe(metro_strobe),
        .rms_in(rms_in), .rate_div(rate_div), .relay_req(relay_req),
        .rx_flag_clr(rx_flag_clr), .serial_data_in(miso), .driver_fault_flag_1(flt1),
        .driver_fault_flag_2(flt2), .channel_jumper_inputs(chan_in),
        .mode_jumper_inputs(mode_in), .sclk(sclk), .serial_data_out(mosi),
        .dac_chip_select_n(cs_n), .channel_jumper_out(chan_out),
        .channel_jumper_oe(chan_oe), .mode_jumper_out(mode_out),
        .mode_jumper_oe(mode_oe), .driver_mode_outputs(modes), .relay_out(relay_out),
        .led_out(leds), .spi_rx_irq(irq), .spi_rx_byte(rx_byte),
        .init_done(init_done), .frame_busy(frame_busy));
    ddos_dac_model #(.REPLY(8'hA5)) dac_u (.sclk(sclk), .mosi(mosi), .cs_n(cs_n),
        .miso(miso), .frame(frame), .nframes(nframes), .bad(bad));
    task automatic wrap_up;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic cmpv(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpv
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic pulse;
        metro_strobe = 1'b1;
        tick(1);
        metro_strobe = 1'b0;
    endtask : pulse
    // Waits for the next closed frame and compares its three bytes
    task automatic chk_frame(input logic [23:0] exp);
        int n0;
        int k;
        n0 = nframes;
        k = 0;
        while (nframes == n0 && k < 40000) begin
            tick(1);
            k++;
        end
        cmpv(frame, exp);
    endtask : chk_frame
    // Length of the next low half of the serial clock in core cycles
    task automatic meas_low(input int exp);
        int k;
        int n;
        k = 0;
        n = 0;
        while (sclk !== 1'b0 && k < 5000) begin
            tick(1);
            k++;
        end
        while (sclk === 1'b0 && n < 5000) begin
            tick(1);
            n++;
        end
        cmpv(24'(n), 24'(exp));
    endtask : meas_low
    function automatic logic [15:0] ip(input int lo, hi, r, s);
        return 16'(lo + (hi - lo) * r / s);
    endfunction : ip
    initial begin
        int n0;
        tick(9);
        cmpv(24'({sclk, cs_n}), 24'h3);
        cmpv(24'(modes), 24'h2);
        cmpv(24'({relay_out, leds}), 24'h0);
        tick(1);
        resetn = 1'b1;
        tick(2);
        cmpv(24'({chan_oe, chan_out}), 24'h00_AAAA);
        cmpv(24'({mode_oe, mode_out}), 24'h00_0202);
        chk_frame({CMD_REF, REF_HI, REF_LO});
        cmpv(24'(irq), 24'h0);
        chk_frame({CMD_BOTH, CODE_MID});
        cmpv(24'({init_done, frame_busy}), 24'h1);
        rms_in[0] = {16'h1388, 16'h0384};
        rms_in[1] = {16'h05DC, 16'h0177};
        rms_in[2] = {16'h2328, 16'h0BB8};
        chan_fit = 8'h50;
        mode_fit = 8'h05;
        tick(600);
        cmpv(24'({init_done, frame_busy}), 24'h2);
        pulse();
        chk_frame({CMD_CHA, ip(CUR_TAB[1], CUR_TAB[2], 500, CUR_STEP)});
        chk_frame({CMD_CHB, ip(VOLT_TAB[1], VOLT_TAB[2], 125, VOLT_STEP)});
        cmpv(24'(modes), 24'h3);
        tick(10);
        cmpv(24'(rx_byte), 24'hA5);
        cmpv(24'(irq), 24'h1);
        rx_flag_clr = 1'b1;
        tick(2);
        rx_flag_clr = 1'b0;
        tick(2);
        cmpv(24'(irq), 24'h0);
        chan_fit = 8'h00;
        mode_fit = 8'h01;
        tick(200);
        n0 = nframes;
        pulse();
        tick(20);
        cmpv(24'(nframes - n0), 24'h0);
        cmpv(24'(modes), 24'h1);
        rate_div = 16'h0000;
        pulse();
        meas_low(HALF_DEF);
        pulse();
        chk_frame({CMD_BOTH, CODE_MID});
        n0 = nframes;
        tick(300);
        cmpv(24'(nframes - n0), 24'h0);
        rate_div = 16'h000A;
        pulse();
        meas_low(HALF_MIN);
        chk_frame({CMD_BOTH, CODE_MID});
        cmpv(24'(bad), 24'h0);
        relay_req = 6'h2D;
        tick(3);
        cmpv(24'(relay_out), 24'h2D);
        flt1 = 1'b0;
        tick(6);
        cmpv(24'(leds), 24'h1);
        flt1 = 1'b1;
        flt2 = 1'b0;
        tick(6);
        cmpv(24'(leds), 24'h2);
        // Phase 1 and 2 jumpers fitted: phase 1 must win
        chan_fit = 8'h14;
        pulse();
        tick(300);
        pulse();
        chk_frame({CMD_CHA, CUR_TAB[5]});
        chk_frame({CMD_CHB, ip(VOLT_TAB[3], VOLT_TAB[4], 150, VOLT_STEP)});
        cmpv(24'(bad), 24'h0);
        wrap_up();
    end
    initial begin
        #1_800_000;
        num_errors++;
        wrap_up();
    end
endmodule : ddos_dac_seq_tb
